// ### inc/backup_ctrl_consts.vh
`ifndef BACKUP_CTRL_CONSTS_VH
`define BACKUP_CTRL_CONSTS_VH

// clock rate of clk_in
`define CLK_FREQ_MHZ      125
// self-timed transfer durations, in microseconds
`define STORE_TIME_US     10000
`define RESTORE_TIME_US   5000
// width of the transfer timer
`define TIMER_W           32
// backup copy of the configuration bits after reset (factory state)
`define BP_RESET          2'h0
`define ROLLOVER_RESET    1'h0
`define ASE_RESET         1'h0
// timer constants
`define TMR_ZERO          32'h0
`define TMR_ONE           32'h1

`endif

// ### design/xfer_timer.v
`timescale 1ns/1ps

// counts one self-timed transfer; done_out pulses once when it runs out
module xfer_timer
#(
    parameter W = 32
)
(
    input  wire         clk_in,
    input  wire         rstn_in,
    input  wire         ce_in,
    input  wire         start_in,
    input  wire         abort_in,
    input  wire [W-1:0] count_in,
    output reg          done_out
);

    reg [W-1:0] cnt_reg;
    wire [W-1:0] zero_w = {W{1'b0}};
    wire [W-1:0] one_w  = {{(W-1){1'b0}}, 1'b1};

    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            cnt_reg  <= {W{1'b0}};
            done_out <= 1'b0;
        end
        else if (ce_in)
        begin
            done_out <= 1'b0;
            if (abort_in)
                cnt_reg <= zero_w;
            // loading one less puts done on the count-th edge after start;
            // a count below two is not supported
            else if (start_in)
                cnt_reg <= count_in - one_w;
            else if (cnt_reg != zero_w)
            begin
                cnt_reg <= cnt_reg - one_w;
                done_out <= (cnt_reg == one_w);
            end
        end
    end

endmodule

// ### design/backup_store_recall_control.v
`timescale 1ns/1ps
`include "backup_ctrl_consts.vh"

module backup_store_recall_control
#(
    parameter STORE_CYCLES   = `STORE_TIME_US * `CLK_FREQ_MHZ,
    parameter RESTORE_CYCLES = `RESTORE_TIME_US * `CLK_FREQ_MHZ
)
(
    input  wire       clk_in,
    input  wire       rstn_in,
    input  wire       ce_in,
    input  wire       cap_above_trip_in,
    input  wire       vcc_above_cap_in,
    input  wire       cs_n_in,
    input  wire       cmd_store_in,
    input  wire       cmd_recall_in,
    input  wire       cmd_hibernate_in,
    input  wire       array_write_in,
    input  wire [1:0] block_protect_bits_in,
    input  wire       rollover_select_in,
    input  wire       automatic_save_disable_in,
    output reg        busy_flag_out,
    output reg        cmd_enable_out,
    output reg        status_enable_out,
    output reg        so_enable_out,
    output reg        store_start_out,
    output reg        recall_start_out,
    output reg        recall_abort_out,
    output reg        cfg_load_out,
    output reg  [1:0] block_protect_bits_out,
    output reg        rollover_select_out,
    output reg        automatic_save_disable_out,
    output reg        modified_out,
    output reg        low_power_out,
    output reg        vcc_connect_out
);

    localparam [2:0] ST_OFF        = 3'h0;
    localparam [2:0] ST_RECALL     = 3'h1;
    localparam [2:0] ST_READY      = 3'h2;
    localparam [2:0] ST_STORE      = 3'h3;
    localparam [2:0] ST_AUTO_STORE = 3'h4;
    localparam [2:0] ST_HIB_SAVE   = 3'h5;
    localparam [2:0] ST_HIB        = 3'h6;

    // transfer lengths are cut to the timer width; the defaults fit
    localparam [`TIMER_W-1:0] STORE_CNT   = STORE_CYCLES;
    localparam [`TIMER_W-1:0] RESTORE_CNT = RESTORE_CYCLES;

    // pin synchronisers; the first stage feeds only the second
    reg cap_meta_reg;
    reg cap_sync_reg;
    reg cap_prev_reg;
    reg vcc_meta_reg;
    reg vcc_sync_reg;
    reg cs_meta_reg;
    reg cs_sync_reg;
    reg cs_prev_reg;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg       hib_pend_reg;
    reg       hib_pend_next;
    reg       modified_reg;
    reg       modified_next;
    reg [1:0] saved_bp_reg;
    reg       saved_ro_reg;
    reg       saved_ase_reg;

    reg       tmr_start;
    reg       tmr_store;
    reg       do_store;
    reg       do_recall;
    reg       do_abort;
    reg       do_cfg_load;

    wire      tmr_done;
    wire      cap_rise = cap_sync_reg & ~cap_prev_reg;
    wire      cap_fall = ~cap_sync_reg & cap_prev_reg;
    wire      cs_rise  = cs_sync_reg & ~cs_prev_reg;
    wire      cs_fall  = ~cs_sync_reg & cs_prev_reg;
    // one timer serves both transfer kinds, since only one can run at a time
    wire [`TIMER_W-1:0] tmr_count = tmr_store ? STORE_CNT : RESTORE_CNT;

    xfer_timer
    #(
        .W (`TIMER_W)
    )
    u_timer
    (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .ce_in    (ce_in),
        .start_in (tmr_start),
        .abort_in (do_abort),
        .count_in (tmr_count),
        .done_out (tmr_done)
    );

    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            cap_meta_reg <= 1'b0;
            cap_sync_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
            vcc_meta_reg <= 1'b0;
            vcc_sync_reg <= 1'b0;
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            cs_prev_reg  <= 1'b1;
        end
        else if (ce_in)
        begin
            cap_meta_reg <= cap_above_trip_in;
            cap_sync_reg <= cap_meta_reg;
            cap_prev_reg <= cap_sync_reg;
            vcc_meta_reg <= vcc_above_cap_in;
            vcc_sync_reg <= vcc_meta_reg;
            cs_meta_reg  <= cs_n_in;
            cs_sync_reg  <= cs_meta_reg;
            cs_prev_reg  <= cs_sync_reg;
        end
    end

    always @*
    begin
        state_next    = state_reg;
        hib_pend_next = hib_pend_reg;
        tmr_start     = 1'b0;
        tmr_store     = 1'b0;
        do_store      = 1'b0;
        do_recall     = 1'b0;
        do_abort      = 1'b0;
        do_cfg_load   = 1'b0;
        modified_next = modified_reg;
        case (state_reg)
            ST_OFF:
            begin
                // the first rise after reset is caught because prev starts low
                if (cap_rise)
                begin
                    state_next = ST_RECALL;
                    tmr_start  = 1'b1;
                    do_recall  = 1'b1;
                end
            end
            ST_RECALL:
            begin
                if (cap_fall)
                begin
                    state_next = ST_OFF;
                    do_abort   = 1'b1;
                end
                else if (tmr_done)
                begin
                    state_next  = ST_READY;
                    do_cfg_load = 1'b1;
                end
            end
            ST_READY:
            begin
                if (cap_fall)
                begin
                    hib_pend_next = 1'b0;
                    if (!automatic_save_disable_in && modified_reg)
                    begin
                        state_next = ST_AUTO_STORE;
                        tmr_start  = 1'b1;
                        tmr_store  = 1'b1;
                        do_store   = 1'b1;
                    end
                    else
                        state_next = ST_OFF;
                end
                else if (cmd_store_in)
                begin
                    state_next = ST_STORE;
                    tmr_start  = 1'b1;
                    tmr_store  = 1'b1;
                    do_store   = 1'b1;
                end
                else if (cmd_recall_in)
                begin
                    state_next = ST_RECALL;
                    tmr_start  = 1'b1;
                    do_recall  = 1'b1;
                end
                else if (cmd_hibernate_in)
                    hib_pend_next = 1'b1;
                else if (hib_pend_reg && cs_rise)
                begin
                    hib_pend_next = 1'b0;
                    if (modified_reg)
                    begin
                        state_next = ST_HIB_SAVE;
                        tmr_start  = 1'b1;
                        tmr_store  = 1'b1;
                        do_store   = 1'b1;
                    end
                    else
                        state_next = ST_HIB;
                end
            end
            ST_STORE, ST_AUTO_STORE, ST_HIB_SAVE:
            begin
                // a save always runs out, even if the supply drops or returns
                if (tmr_done)
                begin
                    if (!cap_sync_reg)
                        state_next = ST_OFF;
                    else if (state_reg == ST_AUTO_STORE)
                    begin
                        state_next = ST_RECALL;
                        tmr_start  = 1'b1;
                        do_recall  = 1'b1;
                    end
                    else if (state_reg == ST_HIB_SAVE)
                        state_next = ST_HIB;
                    else
                        state_next = ST_READY;
                end
            end
            ST_HIB:
            begin
                // the synchronisers keep running so chip select can wake us
                if (cap_fall)
                    state_next = ST_OFF;
                else if (cs_fall)
                begin
                    state_next = ST_RECALL;
                    tmr_start  = 1'b1;
                    do_recall  = 1'b1;
                end
            end
            default:
            begin
                state_next    = ST_OFF;
                hib_pend_next = 1'b0;
            end
        endcase
        // clear on completion; a write never falls in that cycle, since it only marks in ST_READY
        if (tmr_done)
            modified_next = 1'b0;
        if (array_write_in && state_reg == ST_READY && !cap_fall)
            modified_next = 1'b1;
    end

    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            state_reg              <= ST_OFF;
            hib_pend_reg           <= 1'b0;
            modified_reg           <= 1'b0;
            saved_bp_reg           <= `BP_RESET;
            saved_ro_reg           <= `ROLLOVER_RESET;
            saved_ase_reg          <= `ASE_RESET;
            busy_flag_out          <= 1'b0;
            cmd_enable_out         <= 1'b0;
            status_enable_out      <= 1'b0;
            so_enable_out          <= 1'b0;
            store_start_out        <= 1'b0;
            recall_start_out       <= 1'b0;
            recall_abort_out       <= 1'b0;
            cfg_load_out           <= 1'b0;
            block_protect_bits_out <= `BP_RESET;
            rollover_select_out    <= `ROLLOVER_RESET;
            automatic_save_disable_out  <= `ASE_RESET;
            modified_out           <= 1'b0;
            low_power_out          <= 1'b0;
            vcc_connect_out        <= 1'b0;
        end
        else if (ce_in)
        begin
            state_reg        <= state_next;
            hib_pend_reg     <= hib_pend_next;
            modified_reg     <= modified_next;
            modified_out     <= modified_next;
            store_start_out  <= do_store;
            recall_start_out <= do_recall;
            recall_abort_out <= do_abort;
            cfg_load_out     <= do_cfg_load;
            if (do_store)
            begin
                saved_bp_reg  <= block_protect_bits_in;
                saved_ro_reg  <= rollover_select_in;
                saved_ase_reg <= automatic_save_disable_in;
            end
            if (do_cfg_load)
            begin
                block_protect_bits_out <= saved_bp_reg;
                rollover_select_out    <= saved_ro_reg;
                automatic_save_disable_out  <= saved_ase_reg;
            end
            // busy follows the state live, so a held status read sees it drop
            busy_flag_out <= (state_next == ST_RECALL) ||
                             (state_next == ST_STORE) ||
                             (state_next == ST_AUTO_STORE) ||
                             (state_next == ST_HIB_SAVE);
            // shown in step with the state; the state itself gates the commands
            cmd_enable_out <= (state_next == ST_READY) &&
                              cap_sync_reg;
            status_enable_out <= cap_sync_reg &&
                                 (state_next != ST_OFF) &&
                                 (state_next != ST_HIB);
            so_enable_out <= cap_sync_reg &&
                             (state_next != ST_OFF) &&
                             (state_next != ST_HIB);
            low_power_out <= (state_next == ST_HIB);
            // the switch is not closed while a save runs, so the cap is not drained
            // back into a sagging supply
            if (cap_fall)
                vcc_connect_out <= 1'b0;
            else if (vcc_sync_reg &&
                     (state_next != ST_STORE) &&
                     (state_next != ST_AUTO_STORE) &&
                     (state_next != ST_HIB_SAVE))
                vcc_connect_out <= 1'b1;
        end
    end

endmodule

// ### tb/backup_ctrl_properties.sv
`timescale 1ns/1ps
module backup_ctrl_properties
#(
    parameter STORE_CYCLES   = 20,
    parameter RESTORE_CYCLES = 10
)
(
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire cap_above_trip_in,
    input wire vcc_above_cap_in,
    input wire cmd_store_in,
    input wire cmd_recall_in,
    input wire array_write_in,
    input wire busy_flag_out,
    input wire cmd_enable_out,
    input wire so_enable_out,
    input wire store_start_out,
    input wire recall_start_out,
    input wire recall_abort_out,
    input wire modified_out,
    input wire vcc_connect_out
);
    integer cnt_reg;
    integer len_reg;
    reg     abort_reg;
    reg     save_reg;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    // an aborted reload ends busy early, so its length is not judged
    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            abort_reg <= 1'b1;
            save_reg  <= 1'b0;
        end
        else
        begin
            if (store_start_out || recall_start_out)
            begin
                cnt_reg   <= 1;
                len_reg   <= store_start_out ? STORE_CYCLES : RESTORE_CYCLES;
                abort_reg <= 1'b0;
            end
            else if (busy_flag_out && ce_in)
                cnt_reg <= cnt_reg + 1;
            if (recall_abort_out)
                abort_reg <= 1'b1;
            if (store_start_out)
                save_reg <= 1'b1;
            else if (!busy_flag_out || recall_start_out)
                save_reg <= 1'b0;
        end
    end
    a_busy_len_exact: assert property ($fell(busy_flag_out) |->
        abort_reg || recall_abort_out || $past(recall_abort_out)
        || cnt_reg == len_reg) else $error("busy length wrong");
    a_busy_locks_cmds: assert property (
        busy_flag_out |-> !cmd_enable_out) else $error("cmd open in busy");
    a_cmd_ignored: assert property (
        busy_flag_out && (cmd_store_in || cmd_recall_in) |=>
        !store_start_out && !recall_start_out) else $error("cmd taken");
    a_store_taken: assert property (
        cap_above_trip_in [*4] ##0 (cmd_store_in && cmd_enable_out) |=>
        store_start_out && busy_flag_out) else $error("store not run");
    a_trip_silent: assert property (!cap_above_trip_in [*4] |->
        !so_enable_out && !cmd_enable_out) else $error("active below trip");
    a_auto_save_gate: assert property (
        store_start_out && !$past(cmd_store_in) |-> $past(modified_out))
        else $error("unmodified save");
    a_write_marks: assert property (
        cap_above_trip_in [*3] ##0 (array_write_in && cmd_enable_out)
        |=> modified_out) else $error("modified not set");
    a_busy_no_mark: assert property (
        busy_flag_out && array_write_in && !modified_out |=> !modified_out)
        else $error("write taken in busy");
    a_abort_no_save: assert property (
        recall_abort_out |=> !store_start_out [*8])
        else $error("save after abort");
    a_reconnect_safe: assert property ($rose(vcc_connect_out) |->
        !(save_reg && cnt_reg != len_reg) && $past(vcc_above_cap_in, 3))
        else $error("early reconnect");
endmodule
bind backup_store_recall_control backup_ctrl_properties #(
    .STORE_CYCLES  (STORE_CYCLES),
    .RESTORE_CYCLES(RESTORE_CYCLES)
) chk (.*);

// ### tb/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
(
    input  wire       clk_in,
    input  wire       busy_in,
    input  wire       status_enable_in,
    output reg  [3:0] cmd_out,
    output reg        cs_n_out
);
    initial
    begin
        cmd_out  = 4'h0;
        cs_n_out = 1'b1;
    end
    // one-hot strobe: save, reload, hibernate, array write
    task send(input [3:0] c);
    begin
        @(posedge clk_in);
        #1 cmd_out = c;
        @(posedge clk_in);
        #1 cmd_out = 4'h0;
    end
    endtask
    // one status command, byte clocked out again each cycle until ready
    task poll(input integer limit, output reg done);
        integer n;
    begin
        done = 1'b0;
        for (n = 0; n < limit && !done; n = n + 1)
        begin
            @(posedge clk_in);
            #1 done = status_enable_in && !busy_in;
        end
    end
    endtask
    task select(input v);
    begin
        @(posedge clk_in);
        #1 cs_n_out = v;
    end
    endtask
endmodule

// ### tb/backup_store_recall_control_tb.sv
`timescale 1ns/1ps
module backup_store_recall_control_tb;
    reg        clk_in  = 1'b0;
    reg        rstn_in = 1'b0;
    reg        ce_in   = 1'b1;
    reg        cap_in  = 1'b1;
    reg        vcc_in  = 1'b1;
    reg        asd_in  = 1'b0;
    reg  [1:0] bp_in   = 2'h0;
    reg        ro_in   = 1'b0;
    wire [3:0] cmd;
    wire       cs_n, busy, cmd_en, st_en, so_en, st_go, rc_go, rc_ab, cfg;
    wire [1:0] bp_q;
    wire       ro_q, asd_q, mod, lp, vcc_con;
    integer    miscompares = 0, compares = 0, cycles = 0;
    integer    n_st = 0, n_rc = 0, n_ab = 0, n_ld = 0;
    reg        ok;
    always #4 clk_in = ~clk_in;
    backup_store_recall_control #(
        .STORE_CYCLES  (20),
        .RESTORE_CYCLES(10)
    ) dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .cap_above_trip_in(cap_in), .vcc_above_cap_in(vcc_in),
        .cs_n_in(cs_n), .cmd_store_in(cmd[0]), .cmd_recall_in(cmd[1]),
        .cmd_hibernate_in(cmd[2]), .array_write_in(cmd[3]),
        .block_protect_bits_in(bp_in), .rollover_select_in(ro_in),
        .automatic_save_disable_in(asd_in), .busy_flag_out(busy),
        .cmd_enable_out(cmd_en), .status_enable_out(st_en),
        .so_enable_out(so_en), .store_start_out(st_go),
        .recall_start_out(rc_go), .recall_abort_out(rc_ab),
        .cfg_load_out(cfg), .block_protect_bits_out(bp_q),
        .rollover_select_out(ro_q), .automatic_save_disable_out(asd_q),
        .modified_out(mod), .low_power_out(lp), .vcc_connect_out(vcc_con)
    );
    serial_host_model host (
        .clk_in(clk_in), .busy_in(busy), .status_enable_in(st_en),
        .cmd_out(cmd), .cs_n_out(cs_n)
    );
    task summarize;
    begin
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // pulses are counted at the edge after they appear, never missed
    always @(posedge clk_in)
    begin
        cycles = cycles + 1;
        // outputs are unknown until the first reset edge has passed
        if (rstn_in)
        begin
            n_st = n_st + st_go;
            n_rc = n_rc + rc_go;
            n_ab = n_ab + rc_ab;
            n_ld = n_ld + cfg;
        end
        if (cycles == 2000)
        begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    task check(input [7:0] got, input [7:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    end
    endtask
    task wt(input integer n);
    begin
        repeat (n) @(posedge clk_in);
        #1;
    end
    endtask
    task idle;
    begin
        host.poll(60, ok);
        check(ok, 1'b1);
        // completion pulses come with busy falling and are counted one edge on
        wt(1);
    end
    endtask
    task power(input v);
    begin
        cap_in = v;
        vcc_in = v;
        wt(8);
    end
    endtask
    initial
    begin
        wt(3);
        rstn_in = 1'b1;
        wt(8);
        check(n_rc, 1);
        idle;
        check({n_ld[3:0], bp_q, ro_q, asd_q}, 8'h10);
        bp_in = 2'h2;
        ro_in = 1'b1;
        host.send(4'h1);
        host.send(4'h2);
        check({n_st[3:0], busy, cmd_en}, 8'h06);
        ce_in = 1'b0;
        wt(30);
        check({busy, st_go}, 2'h2);
        ce_in = 1'b1;
        idle;
        check(n_rc, 1);
        bp_in = 2'h1;
        ro_in = 1'b0;
        asd_in = 1'b1;
        host.send(4'h2);
        idle;
        check({n_rc[3:0], bp_q, ro_q, asd_q}, 8'h2A);
        power(1'b0);
        check({n_st[3:0], so_en, cmd_en, vcc_con}, 8'h08);
        power(1'b1);
        idle;
        host.send(4'h8);
        check(mod, 1'b1);
        power(1'b0);
        check(n_st, 1);
        power(1'b1);
        idle;
        check({n_rc[3:0], mod}, 8'h08);
        asd_in = 1'b0;
        host.send(4'h8);
        cap_in = 1'b0;
        vcc_in = 1'b0;
        wt(6);
        check(n_st, 2);
        power(1'b1);
        check({cmd_en, vcc_con}, 2'h0);
        idle;
        check(n_rc, 5);
        power(1'b0);
        cap_in = 1'b1;
        vcc_in = 1'b1;
        wt(5);
        host.send(4'h8);
        power(1'b0);
        check({n_ab[3:0], n_st[3:0]}, 8'h12);
        power(1'b1);
        idle;
        host.select(1'b0);
        host.send(4'h8);
        host.send(4'h4);
        host.select(1'b1);
        wt(30);
        check({n_st[3:0], lp}, 8'h07);
        host.select(1'b0);
        wt(8);
        check({n_rc[3:0], lp}, 8'h10);
        idle;
        check(cmd_en, 1'b1);
        summarize;
    end
endmodule
